// [pkg/pfm_map.svh]
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH

// register byte offsets on the apb slave
`define PFM_OFS_LCR 12'h000
`define PFM_OFS_PCR 12'h004
`define PFM_OFS_GIS 12'h008
`define PFM_OFS_PMCSR 12'h00C
`define PFM_OFS_PDCTL 12'h010

// local control register fields
`define PFM_LCR_FILT_HI 6
`define PFM_LCR_FILT_LO 5
`define PFM_LCR_WAKE_EN 7

// pin config register fields
`define PFM_PCR_WPOL_HI 5
`define PFM_PCR_WPOL_LO 4
`define PFM_PCR_POL_HI 27
`define PFM_PCR_POL_LO 16

// global interrupt status fields
`define PFM_GIS_F0_PD 5
`define PFM_GIS_F1_PD 6
`define PFM_GIS_PIN1_EN 21

// function 1 power management control/status fields
`define PFM_PM_STATE_HI 1
`define PFM_PM_STATE_LO 0
`define PFM_PM_EN 8
`define PFM_PM_STATUS 15

// powerdown pin control fields
`define PFM_PD_INT_EN 0
`define PFM_PD_PIN_HI 11
`define PFM_PD_PIN_LO 3

// multi-purpose pin roles
`define PFM_PIN_WAKE 2
`define PFM_PIN_F0 1

// wake polarity codes
`define PFM_WPOL_RISE 2'b00
`define PFM_WPOL_FALL 2'b01

// filter times in seconds and the clock
`define PFM_FILT1_S 4
`define PFM_FILT2_S 129
`define PFM_FILT3_S 518
`define PFM_FILT3_ALT_S 515
`define PFM_CLK_PERIOD_NS 4
`define PFM_NS_PER_S 1000000000

// reset values
`define PFM_RST_WORD 32'h0000_0000

`endif

// [pkg/pfm_pkg.sv]
`default_nettype none

package pfm_pkg;

	// pci power states of function 1
	typedef enum logic [1:0] {
		PFM_D0 = 2'b00,
		PFM_D1 = 2'b01,
		PFM_D2 = 2'b10,
		PFM_D3 = 2'b11
	} pfm_pstate_e;

	// apb slave phase
	typedef enum logic [0:0] {
		PFM_APB_IDLE = 1'b0,
		PFM_APB_ACK = 1'b1
	} pfm_apb_e;

	// width of the filter counter, holds 518 s at 250 mhz
	typedef logic [39:0] pfm_cnt_t;

endpackage : pfm_pkg

`default_nettype wire

// [hdl/pfm_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for the multi-purpose pins
module pfm_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// pins in, synchronised copy out
	input wire logic [11:0] pin_in,
	output logic [11:0] pin_out
);

	genvar gi;

	// one pair of flops per pin; stage one feeds stage two only
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : g_bit
			logic meta;
			logic stable;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta <= 1'b0;
					stable <= 1'b0;
				end else if (ce) begin
					meta <= pin_in[gi];
					stable <= meta;
				end
			end
			assign pin_out[gi] = stable;
		end
	endgenerate

endmodule : pfm_sync

`default_nettype wire

// [hdl/pfm_power_manager.sv]
// How it works
// - pins 11..3 request powerdown, pin 2 wakes
// - parallel port, local bus never request power
// - powerdown pin polarity selectable per pin
// - powerdown request follows pin with no filter
// - powerdown request drives function 1 interrupt
// - power state changes only by software write
// - D2/D3 puts parallel port, local bus low-power
// - D2/D3 suppresses function 1 interrupt
// - D2/D3 refuses bar access, config stays open
// - wake output needs the pme enable bit
// - wake condition asserts pme at once
// - wake sets sticky status, write one clears
// - status with enable keeps pme asserted
// - code 00: no f0 powerdown irq, pin 1 irq
// - filter 4 s, 129 s, 518 s or 515 s
// - nonzero code, bit 21 clear: poll only
// - nonzero code, bit 21 set: powerdown irq
// - wake gate and edge select for pin 2
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.svh"

module pfm_power_manager #(
	// filter lengths in clock cycles, full length from the seconds and the clock period
	parameter pfm_pkg::pfm_cnt_t FILT1_CYC = pfm_pkg::pfm_cnt_t'(
		40'(`PFM_FILT1_S) * 40'(`PFM_NS_PER_S) / 40'(`PFM_CLK_PERIOD_NS)),
	parameter pfm_pkg::pfm_cnt_t FILT2_CYC = pfm_pkg::pfm_cnt_t'(
		40'(`PFM_FILT2_S) * 40'(`PFM_NS_PER_S) / 40'(`PFM_CLK_PERIOD_NS)),
	parameter pfm_pkg::pfm_cnt_t FILT3_CYC = pfm_pkg::pfm_cnt_t'(
		40'(`PFM_FILT3_S) * 40'(`PFM_NS_PER_S) / 40'(`PFM_CLK_PERIOD_NS)),
	parameter pfm_pkg::pfm_cnt_t FILT3_ALT_CYC = pfm_pkg::pfm_cnt_t'(
		40'(`PFM_FILT3_ALT_S) * 40'(`PFM_NS_PER_S) /
		40'(`PFM_CLK_PERIOD_NS))
) (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external pins
	input wire logic [11:0] multi_purpose_pin,
	// function 0 side
	input wire logic f0_uart_idle,
	output logic f0_irq,
	// function 1 side
	input wire logic f1_unit_irq,
	output logic f1_irq,
	output logic pp_low_power,
	output logic lb_low_power,
	output logic f1_bar_enable,
	// pme open-drain pin, driven low while enabled
	output logic pme_n_out,
	output logic pme_n_oe
);

	// register state of the block, all but the pin synchroniser flops
	// one flop bank, so a low ce freezes every field at once
	typedef struct packed {
		pfm_pkg::pfm_apb_e apb_ph; // slave phase
		logic pready; // answer strobe
		logic pslverr; // unmapped address answer
		logic [31:0] prdata; // read data
		logic [1:0] filt_code; // function 0 filter code
		logic wake_en; // wake gate for pin 2
		logic [11:0] pin_pol; // 1 selects active low
		logic [1:0] wake_pol; // wake edge code
		logic pin1_en; // global status bit 21
		logic [8:0] pd_pin_en; // pins 11..3 allowed to request
		logic pd_int_en; // powerdown onto function 1 irq
		pfm_pkg::pfm_pstate_e pstate; // function 1 power state
		logic pme_en; // pme enable
		logic pme_status; // sticky wake status
		pfm_pkg::pfm_cnt_t filt_cnt; // function 0 idle time
		logic f0_pd; // function 0 powerdown state
		logic wake_q; // delayed wake pin for edges
		logic f0_irq; // function 0 interrupt
		logic f1_irq; // function 1 interrupt
		logic low_power; // function 1 in D2 or D3
		logic bar_en; // bar access allowed
		logic pme_oe; // pme pin pulled low
	} pfm_state_s;

	pfm_state_s r; // registered state
	pfm_state_s next_r; // next state
	logic [11:0] pin_s; // synchronised pins

	// pins cross into the clock domain first
	// every pin path below is two cycles later than the pin itself
	pfm_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.pin_in(multi_purpose_pin),
		.pin_out(pin_s)
	);

	// next-state logic for the whole block
	always_comb begin
		logic [11:0] pin_act; // pins at their active level
		logic pd_req; // function 1 powerdown request
		logic wake_rise; // edge on the wake pin
		logic wake_fall;
		logic wake_hit; // configured wake condition
		logic acc; // access phase of a transfer
		logic hit; // address is mapped
		logic [31:0] rd; // read mux
		logic clr_status; // write one to status
		logic [1:0] wr_state; // written power state
		pfm_pkg::pfm_cnt_t limit; // selected filter length

		next_r = r;
		pin_act = 12'h000;
		pd_req = 1'b0;
		wake_rise = 1'b0;
		wake_fall = 1'b0;
		wake_hit = 1'b0;
		acc = 1'b0;
		hit = 1'b0;
		rd = `PFM_RST_WORD;
		clr_status = 1'b0;
		wr_state = 2'b00;
		limit = FILT1_CYC;

		// polarity per pin; may match the normal interrupt level
		pin_act = pin_s ^ r.pin_pol;

		// request is a plain level, no timer in its path
		pd_req = |(pin_act[`PFM_PD_PIN_HI:`PFM_PD_PIN_LO] &
			r.pd_pin_en);

		// edge detection on the synchronised wake pin only
		// wake_q resets low; wake_en is low then too, so a pin that
		// idles high leaves no false wake behind after reset
		next_r.wake_q = pin_s[`PFM_PIN_WAKE];
		wake_rise = pin_s[`PFM_PIN_WAKE] & ~r.wake_q;
		wake_fall = ~pin_s[`PFM_PIN_WAKE] & r.wake_q;

		// edge choice by code; 10 and 11 never wake
		case (r.wake_pol)
			`PFM_WPOL_RISE: begin
				wake_hit = r.wake_en & wake_rise;
			end
			`PFM_WPOL_FALL: begin
				wake_hit = r.wake_en & wake_fall;
			end
			default: begin
				wake_hit = 1'b0;
			end
		endcase

		// apb: answer one cycle after the access phase starts
		acc = psel & penable;
		case (paddr)
			`PFM_OFS_LCR: begin
				hit = 1'b1;
				rd = {24'h00_0000, r.wake_en, r.filt_code, 5'h00};
			end
			`PFM_OFS_PCR: begin
				hit = 1'b1;
				rd = {4'h0, r.pin_pol, 10'h000, r.wake_pol, 4'h0};
			end
			`PFM_OFS_GIS: begin
				hit = 1'b1;
				rd = {10'h000, r.pin1_en, 14'h0000, pd_req,
					r.f0_pd, 5'h00};
			end
			`PFM_OFS_PMCSR: begin
				hit = 1'b1;
				rd = {16'h0000, r.pme_status, 6'h00, r.pme_en,
					6'h00, r.pstate};
			end
			`PFM_OFS_PDCTL: begin
				hit = 1'b1;
				rd = {20'h0_0000, r.pd_pin_en, 2'b00, r.pd_int_en};
			end
			default: begin
				hit = 1'b0;
				rd = `PFM_RST_WORD;
			end
		endcase

		// phase machine of the slave
		// read data is taken at the first access edge; a status bit
		// that moves during the wait shows up at the next read
		case (r.apb_ph)
			pfm_pkg::PFM_APB_IDLE: begin
				if (acc) begin
					next_r.apb_ph = pfm_pkg::PFM_APB_ACK;
					next_r.pready = 1'b1;
					next_r.pslverr = ~hit;
					next_r.prdata = (pwrite || !hit) ?
						`PFM_RST_WORD : rd;
				end
			end
			pfm_pkg::PFM_APB_ACK: begin
				// the write lands on the edge that sees pready
				next_r.apb_ph = pfm_pkg::PFM_APB_IDLE;
				next_r.pready = 1'b0;
				next_r.pslverr = 1'b0;
				next_r.prdata = `PFM_RST_WORD;
			end
			default: begin
				next_r.apb_ph = pfm_pkg::PFM_APB_IDLE;
				next_r.pready = 1'b0;
			end
		endcase

		// register writes; config path is open in every state
		// an unmapped offset changes nothing and is flagged by pslverr
		if (r.pready && acc && pwrite) begin
			case (paddr)
				`PFM_OFS_LCR: begin
					next_r.filt_code =
						pwdata[`PFM_LCR_FILT_HI:`PFM_LCR_FILT_LO];
					next_r.wake_en = pwdata[`PFM_LCR_WAKE_EN];
				end
				`PFM_OFS_PCR: begin
					next_r.pin_pol =
						pwdata[`PFM_PCR_POL_HI:`PFM_PCR_POL_LO];
					next_r.wake_pol =
						pwdata[`PFM_PCR_WPOL_HI:`PFM_PCR_WPOL_LO];
				end
				`PFM_OFS_GIS: begin
					next_r.pin1_en = pwdata[`PFM_GIS_PIN1_EN];
				end
				`PFM_OFS_PMCSR: begin
					// only software moves the power state
					wr_state =
						pwdata[`PFM_PM_STATE_HI:`PFM_PM_STATE_LO];
					if (wr_state != 2'(pfm_pkg::PFM_D1)) begin
						// D1 is not supported, the state field of such a write is dropped
						next_r.pstate =
							pfm_pkg::pfm_pstate_e'(wr_state);
					end
					next_r.pme_en = pwdata[`PFM_PM_EN];
					clr_status = pwdata[`PFM_PM_STATUS];
				end
				`PFM_OFS_PDCTL: begin
					next_r.pd_pin_en =
						pwdata[`PFM_PD_PIN_HI:`PFM_PD_PIN_LO];
					next_r.pd_int_en = pwdata[`PFM_PD_INT_EN];
				end
				default: begin
					next_r.pin1_en = r.pin1_en;
				end
			endcase
		end

		// sticky wake status; a wake in the clear cycle wins
		if (wake_hit) begin
			next_r.pme_status = 1'b1;
		end else if (clr_status) begin
			next_r.pme_status = 1'b0;
		end

		// pme pulls low from the next edge, no filter
		// pme_en gates only the pin; status keeps recording wakes
		next_r.pme_oe = next_r.pme_en & next_r.pme_status;

		// function 0 filter length by code, one row quotes 515 s
		case (r.filt_code)
			2'b01: begin
				limit = FILT1_CYC;
			end
			2'b10: begin
				limit = FILT2_CYC;
			end
			2'b11: begin
				limit = r.pin1_en ? FILT3_ALT_CYC : FILT3_CYC;
			end
			default: begin
				limit = FILT1_CYC;
			end
		endcase

		// idle must hold the whole filter time before powerdown
		// the count stops at limit - 1, so f0_pd holds while idle lasts
		// the limit is re-read each cycle, so a code change applies at once
		if (!f0_uart_idle || r.filt_code == 2'b00) begin
			next_r.filt_cnt = '0;
			next_r.f0_pd = 1'b0;
		end else if (r.filt_cnt >= limit - pfm_pkg::pfm_cnt_t'(1)) begin
			next_r.f0_pd = 1'b1;
		end else begin
			next_r.filt_cnt = r.filt_cnt + pfm_pkg::pfm_cnt_t'(1);
		end

		// function 0 interrupt: pin 1 or the powerdown state
		if (r.filt_code == 2'b00) begin
			next_r.f0_irq = r.pin1_en & pin_act[`PFM_PIN_F0];
		end else begin
			// pin 1 is off; bit 21 gates the powerdown interrupt
			next_r.f0_irq = r.pin1_en & r.f0_pd;
		end

		// low power follows the power state, not any unit request
		// taken from next_r so the outputs move at the write edge itself
		next_r.low_power = (next_r.pstate == pfm_pkg::PFM_D2) ||
			(next_r.pstate == pfm_pkg::PFM_D3);
		next_r.bar_en = ~next_r.low_power;

		// function 1 interrupt, silenced in D2 and D3
		next_r.f1_irq = ~next_r.low_power &
			(f1_unit_irq | (r.pd_int_en & pd_req));
	end

	// single state register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// all outputs but pme_n_out come straight from the state register
	// both units share one flop, so they can never disagree
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign f0_irq = r.f0_irq;
	assign f1_irq = r.f1_irq;
	assign pp_low_power = r.low_power;
	assign lb_low_power = r.low_power;
	assign f1_bar_enable = r.bar_en;
	// the pin is only ever driven low
	assign pme_n_out = 1'b0;
	assign pme_n_oe = r.pme_oe;

endmodule : pfm_power_manager

`default_nettype wire

// [testbench/pfm_power_manager_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// port-level checker for the function 1 power manager
module pfm_pm_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// power outputs
	input wire logic f1_irq,
	input wire logic pp_low_power,
	input wire logic lb_low_power,
	input wire logic f1_bar_enable,
	input wire logic pme_n_out,
	input wire logic pme_n_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// access phase still waiting for the slave
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	// write accepted at this edge
	sequence s_wr;
		psel && penable && pready && pwrite;
	endsequence

	a_ready_next: assert property (s_wait |=> pready)
		else $error("pready late");
	a_err_pulse: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata not zero");
	a_units_together: assert property (pp_low_power == lb_low_power)
		else $error("low power outputs differ");
	a_bar_blocked: assert property (pp_low_power |-> !f1_bar_enable)
		else $error("bar open in low power");
	a_irq_muted: assert property (
		pp_low_power && $past(pp_low_power) |-> !f1_irq)
		else $error("irq in low power");
	a_pme_sink: assert property (pme_n_oe |-> pme_n_out == 1'b0)
		else $error("pme not pulled low");
	a_pme_held: assert property (
		pme_n_oe && !psel && !$past(psel) |=> pme_n_oe)
		else $error("pme dropped by itself");
	a_state_by_host: assert property (
		$changed(pp_low_power) |-> $past(pready && pwrite))
		else $error("power state changed without write");
	// write path seen at least once
	c_write: cover property (s_wr);
endmodule : pfm_pm_chk

bind pfm_power_manager pfm_pm_chk chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .f1_irq(f1_irq),
	.pp_low_power(pp_low_power), .lb_low_power(lb_low_power),
	.f1_bar_enable(f1_bar_enable), .pme_n_out(pme_n_out),
	.pme_n_oe(pme_n_oe));

`default_nettype wire

// [testbench/pfm_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

// board pins: follow the wanted level one clock edge late
module pfm_pin_model (
	// clock
	input wire logic pclk,
	// wanted levels, pins out
	input wire logic [11:0] want,
	output logic [11:0] pins
);
	// driven on the edge like any bench input; the sync takes it in
	always @(posedge pclk) begin
		pins <= want;
	end
endmodule : pfm_pin_model

`default_nettype wire

// [testbench/pfm_power_manager_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.svh"

module pfm_power_manager_tb;
	// bench state
	logic pclk, presetn, psel, penable, pwrite, f0_uart_idle, f1_unit_irq;
	logic [11:0] paddr, want, pins;
	logic [31:0] pwdata, prdata, q;
	logic qe; // pslverr taken along with the read data
	logic pready, pslverr, f0_irq, f1_irq, pp_lp, lb_lp, bar, pme_o, pme_e;
	int failures = 0;
	int checks_done = 0;
	int lim[4] = '{8, 16, 24, 8};

	pfm_pin_model pin_u (.pclk(pclk), .want(want), .pins(pins));
	pfm_power_manager #(.FILT1_CYC(40'h8), .FILT2_CYC(40'h10),
		.FILT3_CYC(40'h20), .FILT3_ALT_CYC(40'h18)) dut_u (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .multi_purpose_pin(pins),
		.f0_uart_idle(f0_uart_idle), .f0_irq(f0_irq),
		.f1_unit_irq(f1_unit_irq), .f1_irq(f1_irq),
		.pp_low_power(pp_lp), .lb_low_power(lb_lp),
		.f1_bar_enable(bar), .pme_n_out(pme_o), .pme_n_oe(pme_e));

	// one apb transfer; waits for pready, bounded
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		q = prdata;
		qe = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next call never reassigns in this step
		@(posedge pclk);
	endtask : apb

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// word compare
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t word %h expected %h", $time, g, e);
		end
	endtask : chk

	// flag compare
	task automatic chkb(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t flag %b expected %b", $time, g, e);
		end
	endtask : chkb

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// free-running clock, 4 ns
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// watchdog well past the expected run
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		end_sim;
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, f0_uart_idle, f1_unit_irq} = 5'b0_0000;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		want = 12'h000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values and an unmapped place
		apb(0, `PFM_OFS_PMCSR, 0);
		chk(q, `PFM_RST_WORD);
		chkb(qe, 1'b0);
		apb(0, 12'h020, 0);
		chk(q, 32'h0000_0000);
		chkb(qe, 1'b1);
		$display("test reset done");
		// powerdown pins 11..3 only, no filter, polarity
		apb(1, `PFM_OFS_PDCTL, 32'h0000_0FFD);
		want <= 12'h004;
		cyc(6);
		chkb(f1_irq, 1'b0);
		want <= 12'h800;
		cyc(6);
		chkb(f1_irq, 1'b1);
		apb(0, `PFM_OFS_GIS, 0);
		chkb(q[6], 1'b1);
		apb(1, `PFM_OFS_PCR, 32'h0800_0000);
		cyc(6);
		chkb(f1_irq, 1'b0);
		apb(1, `PFM_OFS_PCR, 32'h0000_0000);
		$display("test powerdown done");
		// normal unit interrupt too, must be muted in D3
		f1_unit_irq <= 1'b1;
		// D3 entry with the request still high
		apb(1, `PFM_OFS_PMCSR, 32'h0000_0003);
		cyc(3);
		chk({pp_lp, lb_lp, bar, f1_irq}, 4'b1100);
		apb(0, `PFM_OFS_PMCSR, 0);
		chk(q, 32'h0000_0003);
		want <= 12'h000;
		$display("test d3 done");
		// wake codes 00..11, then wake gate off
		for (int c = 0; c < 5; c++) begin
			apb(1, `PFM_OFS_LCR, (c < 4) ? 32'h0000_0080 : 32'h0);
			apb(1, `PFM_OFS_PCR, 32'(c % 4) << 4);
			apb(1, `PFM_OFS_PMCSR, 32'h0000_8103);
			want <= 12'h004;
			cyc(8);
			want <= 12'h000;
			cyc(8);
			chkb(pme_e, c < 2);
			apb(0, `PFM_OFS_PMCSR, 0);
			chkb(q[15], c < 2);
		end
		// pme enable off: status only, then on
		apb(1, `PFM_OFS_PCR, 32'h0000_0000);
		apb(1, `PFM_OFS_LCR, 32'h0000_0080);
		apb(1, `PFM_OFS_PMCSR, 32'h0000_8003);
		want <= 12'h004;
		cyc(8);
		chkb(pme_e, 1'b0);
		apb(1, `PFM_OFS_PMCSR, 32'h0000_0103);
		cyc(3);
		chk({pme_o, pme_e}, 2'b01);
		apb(1, `PFM_OFS_PMCSR, 32'h0000_8100);
		cyc(3);
		chk({pme_e, pp_lp, bar, f1_irq}, 4'b0011);
		f1_unit_irq <= 1'b0;
		want <= 12'h000;
		$display("test wake done");
		// function 0: pin 1 path, then filter codes
		apb(1, `PFM_OFS_LCR, 32'h0000_0000);
		apb(1, `PFM_OFS_GIS, 32'h0020_0000);
		want <= 12'h002;
		cyc(6);
		chkb(f0_irq, 1'b1);
		for (int k = 0; k < 4; k++) begin
			apb(1, `PFM_OFS_LCR, 32'(k % 3 + 1) << 5);
			apb(1, `PFM_OFS_GIS, (k < 3) ? 32'h0020_0000 : 32'h0);
			f0_uart_idle <= 1'b1;
			// irq rises exactly one edge after limit idle edges
			cyc(lim[k]);
			chkb(f0_irq, 1'b0);
			cyc(2);
			chkb(f0_irq, k < 3);
			apb(0, `PFM_OFS_GIS, 0);
			chkb(q[5], 1'b1);
			f0_uart_idle <= 1'b0;
			cyc(4);
		end
		$display("test filter done");
		end_sim;
	end
endmodule : pfm_power_manager_tb

`default_nettype wire
